// ### src/scc_config_top.sv
// Configuration logic of a clock synthesizer: a serial two-wire slave with
// two divider configuration registers and a write-only command register,
// plus a parallel pin mode with priority over the serial writes.
// Assumes SCL stays low for at least 5 ref_clk and high for at least 3.
//
// Contract
// RQ1 - Write-only command register at 0xF0
// RQ2 - Step-up adds one to feedback divider
// RQ3 - Step-down subtracts one from feedback divider
// RQ4 - Apply copies configuration registers into dividers
// RQ5 - Fetch copies dividers into configuration registers
// RQ6 - Steps leave configuration registers untouched
// RQ7 - No range checking on divider values
// RQ8 - Register writes alone never change dividers
// RQ9 - Lock bit mirrors PLL lock, unwritable
// RQ10 - Entering serial mode keeps all values
// RQ11 - Entering parallel mode dividers follow pins
// RQ12 - Parallel mode registers mirror dividers; no fetch
// RQ13 - Slave address 10110 plus two pins
// RQ14 - Address LSB: zero write, one read
// RQ15 - Controller sends register then data pairs
// RQ16 - Every written byte acknowledged, any order
// RQ17 - Read returns low then high register
// RQ18 - Command register never read back
// RQ19 - Device reset release loads dividers from pins
// RQ20 - Parallel mode pin changes pass through
// RQ21 - Controller keeps outputs stopped until lock
// RQ22 - Parallel mode ignores writes, still acknowledges
// RQ23 - Low register holds feedback bits 7..0
// RQ24 - High register: fb9..8, pa, pb, pre, lock
// RQ25 - Unknown command codes do nothing
// RQ26 - Steps wrap modulo 1024
`timescale 1ns/100ps
`include "scc_defs.svh"
module scc_config_top (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Device pins
    input  wire logic       device_reset_n,
    input  wire logic       parallel_mode_n,
    input  wire logic [1:0] addr_sel_pin,
    input  wire logic [9:0] cfg_fb_pin,
    input  wire logic [2:0] cfg_post_a_pin,
    input  wire logic       cfg_post_b_pin,
    input  wire logic       cfg_pre_pin,
    input  wire logic       pll_locked,
    // Two-wire serial link
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // Active divider settings
    output logic [9:0]      fb_div,
    output logic [2:0]      post_divider_a,
    output logic            post_divider_b_sel,
    output logic            pre_div
);

    // ======================================================================
    // Helpers
    function automatic scc_pkg::scc_cmd_e cmd_decode(input logic [7:0] b);
        unique case (b[3:0])
            `SCC_CMD_UP:    cmd_decode = scc_pkg::SCC_C_UP;
            `SCC_CMD_DOWN:  cmd_decode = scc_pkg::SCC_C_DOWN;
            `SCC_CMD_APPLY: cmd_decode = scc_pkg::SCC_C_APPLY;
            `SCC_CMD_FETCH: cmd_decode = scc_pkg::SCC_C_FETCH;
            default:        cmd_decode = scc_pkg::SCC_C_NONE; // [RQ25]
        endcase
    endfunction : cmd_decode

    function automatic logic [7:0] high_pack(input scc_pkg::scc_div_s d, input logic lk);
        high_pack = {d.fb[9:8], d.pa, d.pb, d.pre, lk}; // [RQ24] [RQ9]
    endfunction : high_pack

    // ======================================================================
    // Input synchronisation
    scc_sync_if sy ();

    scc_pin_sync u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .raw     ({scl_in, sda_in, device_reset_n, parallel_mode_n, pll_locked,
                   addr_sel_pin, cfg_fb_pin, cfg_post_a_pin, cfg_post_b_pin,
                   cfg_pre_pin}),
        .sy      (sy)
    );

    logic scl_p_q;
    logic sda_p_q;
    logic dev_p_q;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scl_p_q <= 1'h1;
            sda_p_q <= 1'h1;
            dev_p_q <= 1'h1;
        end else begin
            scl_p_q <= sy.scl;
            sda_p_q <= sy.sda;
            dev_p_q <= sy.dev_rst_n;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic dev_rise;
    logic par_mode;

    assign scl_rise  = sy.scl & ~scl_p_q;
    assign scl_fall  = ~sy.scl & scl_p_q;
    assign bus_start = sy.scl & scl_p_q & sda_p_q & ~sy.sda;
    assign bus_stop  = sy.scl & scl_p_q & ~sda_p_q & sy.sda;
    assign dev_rise  = sy.dev_rst_n & ~dev_p_q;
    assign par_mode  = ~sy.par_n;

    // ======================================================================
    // Serial engine
    scc_pkg::scc_state_e state_q;
    scc_pkg::scc_kind_e  kind_q;
    logic [3:0]          bit_cnt_q;
    logic [7:0]          rx_q;
    logic [7:0]          tx_q;
    logic [7:0]          reg_addr_q;
    logic                rd_high_q;
    logic                mack_q;
    scc_pkg::scc_div_s   act_q;
    scc_pkg::scc_div_s   cfg_q;

    logic       addr_hit;
    logic       wr_stb;
    logic [7:0] low_rd;
    logic [7:0] high_rd;

    assign addr_hit = rx_q[7:1] == {`SCC_ADDR_FIXED, sy.addr_sel}; // [RQ13]
    assign wr_stb   = state_q == scc_pkg::SCC_RX_ACK && scl_fall
                      && kind_q == scc_pkg::SCC_K_DATA;
    assign low_rd   = cfg_q.fb[7:0]; // [RQ23]
    assign high_rd  = high_pack(cfg_q, sy.lock);

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !sy.dev_rst_n) begin
            state_q    <= scc_pkg::SCC_IDLE;
            kind_q     <= scc_pkg::SCC_K_ADDR;
            bit_cnt_q  <= 4'h0;
            reg_addr_q <= 8'h00;
            rd_high_q  <= 1'h0;
            mack_q     <= 1'h0;
        end else if (bus_start) begin
            state_q   <= scc_pkg::SCC_RX;
            kind_q    <= scc_pkg::SCC_K_ADDR;
            bit_cnt_q <= 4'h0;
        end else if (bus_stop) begin
            state_q <= scc_pkg::SCC_IDLE;
        end else begin
            unique case (state_q)
                scc_pkg::SCC_IDLE: begin
                end
                scc_pkg::SCC_RX: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == `SCC_BYTE_BITS) begin
                        bit_cnt_q <= 4'h0;
                        if (kind_q == scc_pkg::SCC_K_ADDR && !addr_hit) begin
                            state_q <= scc_pkg::SCC_IDLE;
                        end else begin
                            state_q <= scc_pkg::SCC_RX_ACK; // [RQ16] [RQ22]
                        end
                    end
                end
                scc_pkg::SCC_RX_ACK: begin
                    if (scl_fall) begin
                        state_q <= scc_pkg::SCC_RX;
                        unique case (kind_q)
                            scc_pkg::SCC_K_ADDR: begin
                                if (rx_q[0]) begin // [RQ14]
                                    state_q   <= scc_pkg::SCC_TX; // [RQ17]
                                    rd_high_q <= 1'h1;
                                end else begin
                                    kind_q <= scc_pkg::SCC_K_REG;
                                end
                            end
                            scc_pkg::SCC_K_REG: begin // [RQ15]
                                reg_addr_q <= rx_q;
                                kind_q     <= scc_pkg::SCC_K_DATA;
                            end
                            scc_pkg::SCC_K_DATA: begin
                                kind_q <= scc_pkg::SCC_K_REG;
                            end
                        endcase
                    end
                end
                scc_pkg::SCC_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == `SCC_LAST_BIT) begin
                            bit_cnt_q <= 4'h0;
                            state_q   <= scc_pkg::SCC_TX_ACK;
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                scc_pkg::SCC_TX_ACK: begin
                    if (scl_rise) begin
                        mack_q <= ~sy.sda;
                    end else if (scl_fall) begin
                        state_q   <= mack_q ? scc_pkg::SCC_TX : scc_pkg::SCC_IDLE;
                        rd_high_q <= ~rd_high_q;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rx_q <= 8'h00;
        end else if (state_q == scc_pkg::SCC_RX && scl_rise) begin
            rx_q <= {rx_q[6:0], sy.sda};
        end
    end

    // Reads only ever see the two configuration registers, low first.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tx_q <= 8'hFF;
        end else if (state_q == scc_pkg::SCC_RX_ACK && scl_fall) begin
            tx_q <= low_rd; // [RQ17] [RQ18]
        end else if (state_q == scc_pkg::SCC_TX_ACK && scl_fall) begin
            tx_q <= rd_high_q ? high_rd : low_rd;
        end else if (state_q == scc_pkg::SCC_TX && scl_fall) begin
            tx_q <= {tx_q[6:0], 1'h1};
        end
    end

    // Registering the enable moves SDA four clocks after the pin fall of SCL, so the
    // controller must hold SCL low for longer than that.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sda_oe_n <= 1'h1;
        end else begin
            sda_oe_n <= !(state_q == scc_pkg::SCC_RX_ACK
                          || (state_q == scc_pkg::SCC_TX && !tx_q[7]));
        end
    end

    assign sda_out = 1'h0;

    // ======================================================================
    // Register writes and commands
    scc_pkg::scc_cmd_e cmd;
    logic              wr_ok;

    assign wr_ok = wr_stb && !par_mode; // [RQ22]
    assign cmd   = (wr_ok && reg_addr_q == `SCC_REG_CMD) ? cmd_decode(rx_q)
                   : scc_pkg::SCC_C_NONE; // [RQ1]

    // Active dividers: pins win over commands; values are never range checked.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            act_q <= '{`SCC_DEF_FB, `SCC_DEF_PA, `SCC_DEF_PB, `SCC_DEF_PRE};
        end else if (dev_rise || par_mode) begin
            act_q <= sy.pins; // [RQ19] [RQ11] [RQ20]
        end else begin
            unique case (cmd)
                scc_pkg::SCC_C_UP:    act_q.fb <= act_q.fb + 10'h001; // [RQ2] [RQ26] [RQ7]
                scc_pkg::SCC_C_DOWN:  act_q.fb <= act_q.fb - 10'h001; // [RQ3] [RQ26]
                scc_pkg::SCC_C_APPLY: act_q <= cfg_q; // [RQ4] [RQ7] [RQ8]
                scc_pkg::SCC_C_FETCH: begin
                end
                scc_pkg::SCC_C_NONE: begin
                end
            endcase
        end
    end

    // Configuration registers keep their values across a mode change to serial.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg_q <= '{`SCC_DEF_FB, `SCC_DEF_PA, `SCC_DEF_PB, `SCC_DEF_PRE};
        end else if (par_mode) begin
            cfg_q <= sy.pins; // [RQ12] [RQ10]
        end else if (cmd == scc_pkg::SCC_C_FETCH) begin // [RQ6]
            cfg_q <= act_q; // [RQ5]
        end else if (wr_ok && reg_addr_q == `SCC_REG_LOW) begin
            cfg_q.fb[7:0] <= rx_q; // [RQ23]
        end else if (wr_ok && reg_addr_q == `SCC_REG_HIGH) begin
            cfg_q.fb[9:8] <= rx_q[`SCC_HI_FB_MSB:`SCC_HI_FB_LSB]; // [RQ24]
            cfg_q.pa      <= rx_q[`SCC_HI_PA_MSB:`SCC_HI_PA_LSB];
            cfg_q.pb      <= rx_q[`SCC_HI_PB];
            cfg_q.pre     <= rx_q[`SCC_HI_PRE]; // [RQ9]
        end
    end

    assign fb_div             = act_q.fb;
    assign post_divider_a     = act_q.pa;
    assign post_divider_b_sel = act_q.pb;
    assign pre_div            = act_q.pre;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    logic quiet;
    assign quiet = !dev_rise && !par_mode;

    step_up_a: assert property (cmd == scc_pkg::SCC_C_UP && quiet |=> // [RQ2]
        fb_div == 10'($past(fb_div) + 10'h001)) else $error("step up wrong");
    step_down_a: assert property (cmd == scc_pkg::SCC_C_DOWN && quiet |=> // [RQ3]
        fb_div == 10'($past(fb_div) - 10'h001)) else $error("step down wrong");
    apply_copy_a: assert property (cmd == scc_pkg::SCC_C_APPLY && quiet |=> // [RQ4]
        act_q == $past(cfg_q)) else $error("apply did not copy");
    fetch_copy_a: assert property (cmd == scc_pkg::SCC_C_FETCH |=> // [RQ5]
        cfg_q == $past(act_q)) else $error("fetch did not copy");
    step_keeps_cfg_a: assert property ((cmd == scc_pkg::SCC_C_UP // [RQ6]
        || cmd == scc_pkg::SCC_C_DOWN) |=> $stable(cfg_q)) else $error("step changed cfg");
    cfg_write_iso_a: assert property (wr_ok && reg_addr_q != `SCC_REG_CMD // [RQ8]
        && quiet |=> $stable(act_q)) else $error("register write moved divider");
    lock_mirror_a: assert property (rd_high_q && scl_fall // [RQ9]
        && state_q == scc_pkg::SCC_TX_ACK |=> tx_q[`SCC_HI_LOCK] == $past(sy.lock))
        else $error("lock bit not mirrored");
    par_follow_a: assert property (par_mode |=> act_q == $past(sy.pins) // [RQ11]
        && cfg_q == $past(sy.pins)) else $error("parallel mode not followed");
    dev_load_a: assert property (dev_rise |=> act_q == $past(sy.pins)) // [RQ19]
        else $error("reset release did not load pins");
    par_nowrite_a: assert property (wr_stb && par_mode && !$rose(sy.par_n) |=> // [RQ22]
        cfg_q == $past(sy.pins)) else $error("write in parallel mode took effect");
    ack_drive_a: assert property (state_q == scc_pkg::SCC_RX_ACK // [RQ16]
        ##1 state_q == scc_pkg::SCC_RX_ACK |-> !sda_oe_n) else $error("byte not acknowledged");
    ser_keep_a: assert property ($rose(sy.par_n) && !dev_rise && !wr_stb // [RQ10]
        |=> $stable(act_q) && $stable(cfg_q)) else $error("serial entry moved settings");

    apply_seen_c: cover property (cmd == scc_pkg::SCC_C_APPLY);
    read_seen_c: cover property (state_q == scc_pkg::SCC_TX_ACK && rd_high_q);
    par_entry_c: cover property ($fell(sy.par_n));
    wrap_seen_c: cover property (cmd == scc_pkg::SCC_C_UP && fb_div == 10'h3FF);

endmodule : scc_config_top

// ### src/scc_defs.svh
// Constants of the synthesizer configuration block: register offsets,
// command codes, field positions, slave address and reset values.
// Assumes nothing; holds definitions only.
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// ==========================================================================
// Register offsets
`define SCC_REG_LOW      8'h00
`define SCC_REG_HIGH     8'h01
`define SCC_REG_CMD      8'hF0

// ==========================================================================
// Command codes, low nibble of the command byte
`define SCC_CMD_UP       4'h1
`define SCC_CMD_DOWN     4'h2
`define SCC_CMD_APPLY    4'h4
`define SCC_CMD_FETCH    4'h8

// ==========================================================================
// Upper configuration register field positions
`define SCC_HI_LOCK      0
`define SCC_HI_PRE       1
`define SCC_HI_PB        2
`define SCC_HI_PA_LSB    3
`define SCC_HI_PA_MSB    5
`define SCC_HI_FB_LSB    6
`define SCC_HI_FB_MSB    7

// ==========================================================================
// Serial link constants
`define SCC_ADDR_FIXED   5'h16
`define SCC_BYTE_BITS    4'h8
`define SCC_LAST_BIT     4'h7
`define SCC_SYNC_W       22
`define SCC_SYNC_RST     22'h3FFFFF

// ==========================================================================
// Divider values after system reset
`define SCC_DEF_FB       10'h1F4
`define SCC_DEF_PA       3'h2
`define SCC_DEF_PB       1'h0
`define SCC_DEF_PRE      1'h1

`endif

// ### src/scc_pkg.sv
// Types of the synthesizer configuration block.
// Assumes scc_defs.svh supplies the numeric constants.
package scc_pkg;

    // ======================================================================
    // Divider set, used for pins, active dividers and configuration copy
    typedef struct packed {
        logic [9:0] fb;
        logic [2:0] pa;
        logic       pb;
        logic       pre;
    } scc_div_s;

    // ======================================================================
    // Serial engine states, byte kinds and decoded commands
    typedef enum logic [2:0] {
        SCC_IDLE, SCC_RX, SCC_RX_ACK, SCC_TX, SCC_TX_ACK
    } scc_state_e;

    typedef enum logic [1:0] {
        SCC_K_ADDR, SCC_K_REG, SCC_K_DATA
    } scc_kind_e;

    typedef enum logic [2:0] {
        SCC_C_NONE, SCC_C_UP, SCC_C_DOWN, SCC_C_APPLY, SCC_C_FETCH
    } scc_cmd_e;

endpackage : scc_pkg

// ### src/scc_sync_if.sv
// Synchronised pin levels passed from the pin synchroniser to the core.
// Assumes both ends run on ref_clk.
`timescale 1ns/100ps
interface scc_sync_if;
    logic              scl;
    logic              sda;
    logic              dev_rst_n;
    logic              par_n;
    logic              lock;
    logic [1:0]        addr_sel;
    scc_pkg::scc_div_s pins;

    modport src (output scl, sda, dev_rst_n, par_n, lock, addr_sel, pins);
    modport dst (input  scl, sda, dev_rst_n, par_n, lock, addr_sel, pins);
endinterface : scc_sync_if

// ### src/scc_pin_sync.sv
// Two-stage synchroniser for every asynchronous input of the block.
// Assumes all inputs are unrelated to ref_clk.
`timescale 1ns/100ps
`include "scc_defs.svh"
module scc_pin_sync (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Raw inputs
    input  wire logic [`SCC_SYNC_W-1:0] raw,
    // Synchronised levels
    scc_sync_if.src                    sy
);
    logic [`SCC_SYNC_W-1:0] meta_q;
    logic [`SCC_SYNC_W-1:0] sync_q;

    // ======================================================================
    // Resetting to ones keeps the bus idle and the reset pin released.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_q <= `SCC_SYNC_RST;
            sync_q <= `SCC_SYNC_RST;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    assign {sy.scl, sy.sda, sy.dev_rst_n, sy.par_n, sy.lock, sy.addr_sel, sy.pins} = sync_q;

endmodule : scc_pin_sync

// ### tb/scc_i2c_host.sv
// Behavioural two-wire bus controller that stands in front of the configuration block.
// Assumes SDA has a pull-up, so a released line reads high, and that ref_clk runs at 100 MHz.
`timescale 1ns/100ps
module scc_i2c_host (
    // Clock
    input  wire logic ref_clk,
    // Resolved bus level
    input  wire logic sda_wire,
    // Controller drive
    output logic      scl,
    output logic      sda_rel
);
    // ======================================================================
    // Bus phases
    // A bit lasts 80 ns: SCL low for 5 clocks, since the slave turns SDA round
    // 4 clocks after a fall, then high for 3.
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : hold

    task automatic start();
        sda_rel <= 1'b1;
        hold(5);
        scl <= 1'b1;
        hold(20);
        sda_rel <= 1'b0;
        hold(20);
        scl <= 1'b0;
        hold(10);
    endtask : start

    // SCL idles high between frames, so stop leaves it standing there.
    task automatic stop();
        sda_rel <= 1'b0;
        hold(10);
        scl <= 1'b1;
        hold(20);
        sda_rel <= 1'b1;
        hold(20);
    endtask : stop

    task automatic bit_io(input logic b, output logic r);
        sda_rel <= b;
        hold(2);
        scl <= 1'b1;
        hold(3);
        r = sda_wire;
        scl <= 1'b0;
        hold(3);
    endtask : bit_io

    // Register address then data byte order is the caller's to keep.
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask : rd_byte
endmodule : scc_i2c_host

// ### tb/scc_config_top_tb.sv
// Self-checking bench for the synthesizer configuration block.
// Assumes the design sources and the bus controller model are compiled first.
`timescale 1ns/100ps
`include "scc_defs.svh"
module scc_config_top_tb;
    // ======================================================================
    // Stimulus and wiring
    localparam scc_pkg::scc_div_s DEF = {`SCC_DEF_FB, `SCC_DEF_PA, `SCC_DEF_PB, `SCC_DEF_PRE};
    localparam scc_pkg::scc_div_s PA  = {10'h2A5, 3'h5, 1'h1, 1'h0};
    localparam scc_pkg::scc_div_s PB  = {10'h0C3, 3'h1, 1'h0, 1'h1};
    localparam scc_pkg::scc_div_s PC  = {10'h15A, 3'h6, 1'h1, 1'h0};
    localparam scc_pkg::scc_div_s SV  = {10'h3FF, 3'h5, 1'h0, 1'h1};
    logic              ref_clk;
    logic              sys_rst;
    logic              dev_rst_n;
    logic              par_n;
    logic              locked;
    logic [1:0]        asel;
    scc_pkg::scc_div_s pin;
    logic              scl;
    logic              host_rel;
    wire logic         sda_w;
    logic              sda_out;
    logic              sda_oe_n;
    logic [9:0]        fb_div;
    logic [2:0]        post_divider_a;
    logic              post_divider_b_sel;
    logic              pre_div;
    int                n_fail;
    int                tests_run;
    int                cycles;

    // Open-drain wire with a pull-up: low if either party pulls.
    assign sda_w = host_rel & (sda_oe_n | sda_out);

    scc_config_top dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .device_reset_n(dev_rst_n),
        .parallel_mode_n(par_n), .addr_sel_pin(asel), .cfg_fb_pin(pin.fb),
        .cfg_post_a_pin(pin.pa), .cfg_post_b_pin(pin.pb), .cfg_pre_pin(pin.pre),
        .pll_locked(locked), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .fb_div(fb_div), .post_divider_a(post_divider_a),
        .post_divider_b_sel(post_divider_b_sel), .pre_div(pre_div)
    );

    scc_i2c_host host (.ref_clk(ref_clk), .sda_wire(sda_w), .scl(scl), .sda_rel(host_rel));

    initial begin
        ref_clk = 1'b0;
    end
    always #5 ref_clk = ~ref_clk;

    // ======================================================================
    // Checking and closing
    task automatic report_and_stop();
        $display("checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_div(input scc_pkg::scc_div_s exp);
        scc_pkg::scc_div_s got;
        got = {fb_div, post_divider_a, post_divider_b_sel, pre_div};
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_div

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, n_fail);
    endtask : end_test

    // ======================================================================
    // Register access through the two-wire link
    // Sends up to four bytes after the write address, most significant byte first.
    task automatic xfer_w(input logic [31:0] b, input int n);
        logic a;
        host.start();
        host.wr_byte({`SCC_ADDR_FIXED, asel, 1'b0}, a);
        chk8({7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            host.wr_byte(b[31-8*i -: 8], a);
            chk8({7'h0, a}, 8'h01);
        end
        host.stop();
        repeat (4) @(posedge ref_clk);
    endtask : xfer_w

    // Reads low, high and low again; the register order wraps while the controller acks.
    task automatic chk_regs(input scc_pkg::scc_div_s e, input logic lk);
        logic       a;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] lo2;
        host.start();
        host.wr_byte({`SCC_ADDR_FIXED, asel, 1'b1}, a);
        chk8({7'h0, a}, 8'h01);
        host.rd_byte(1'b0, lo);
        host.rd_byte(1'b0, hi);
        host.rd_byte(1'b1, lo2);
        host.stop();
        chk8(lo, e.fb[7:0]);
        chk8(hi, {e.fb[9:8], e.pa, e.pb, e.pre, lk});
        chk8(lo2, e.fb[7:0]);
    endtask : chk_regs

    // ======================================================================
    // Test sequence
    initial begin
        logic [7:0]        cmd [5];
        logic [9:0]        efb [5];
        scc_pkg::scc_div_s e;
        logic              a;
        cmd = '{8'h31, 8'h02, 8'h0C, 8'h06, 8'h00};
        efb = '{10'h000, 10'h3FF, 10'h3FF, 10'h3FF, 10'h3FF};
        n_fail = 0;
        tests_run = 0;
        cycles = 0;
        sys_rst = 1'b1;
        dev_rst_n = 1'b0;
        par_n = 1'b1;
        locked = 1'b1;
        asel = 2'h2;
        pin = PA;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_div(DEF);
        chk8({6'h0, sda_out, sda_oe_n}, 8'h01);
        dev_rst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk_div(PA);
        end_test("device_reset");
        xfer_w({`SCC_REG_CMD, 8'h08, 16'h0}, 2);
        chk_regs(PA, 1'b1);
        end_test("fetch");
        xfer_w({`SCC_REG_LOW, 8'hFF, `SCC_REG_HIGH, 8'hEA}, 4);
        xfer_w({8'h05, 8'h77, 16'h0}, 2);
        chk_div(PA);
        chk_regs(SV, 1'b1);
        xfer_w({`SCC_REG_CMD, 8'h04, 16'h0}, 2);
        chk_div(SV);
        end_test("write_apply");
        e = SV;
        for (int i = 0; i < 5; i++) begin
            xfer_w({`SCC_REG_CMD, cmd[i], 16'h0}, 2);
            e.fb = efb[i];
            chk_div(e);
        end
        chk_regs(SV, 1'b1);
        end_test("commands");
        host.start();
        host.wr_byte({`SCC_ADDR_FIXED, ~asel, 1'b0}, a);
        chk8({7'h0, a}, 8'h00);
        host.stop();
        end_test("address");
        @(posedge ref_clk);
        locked <= 1'b0;
        pin <= PB;
        par_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk_div(PB);
        pin <= PC;
        repeat (8) @(posedge ref_clk);
        chk_div(PC);
        xfer_w({`SCC_REG_LOW, 8'h11, `SCC_REG_CMD, 8'h01}, 4);
        chk_div(PC);
        chk_regs(PC, 1'b0);
        par_n <= 1'b1;
        pin <= PA;
        repeat (8) @(posedge ref_clk);
        chk_div(PC);
        chk_regs(PC, 1'b0);
        xfer_w({`SCC_REG_CMD, 8'h01, 16'h0}, 2);
        e = PC;
        e.fb = 10'h15B;
        chk_div(e);
        end_test("parallel_mode");
        report_and_stop();
    end
endmodule : scc_config_top_tb
